// File: common/mpm_pkg.sv
// constants, register map and carrier types for the six-output motor
// modulator; assumes a single 40 MHz clock and a plain register port.

package mpm_pkg;

   // ------------------------------------------------------------
   // widths and counts
   // ------------------------------------------------------------
   localparam int CNT_W = 12;
   localparam int DUTY_W = 16;
   localparam int DB_W = 8;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int NUM_CH = 6;
   localparam int NUM_PAIRS = 3;
   localparam int WID_W = 14;

   // ------------------------------------------------------------
   // register offsets (word index on the register port)
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_CTRL_A = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_CTRL_B = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_OVERRIDE = 4'h2;
   localparam logic [ADDR_W-1:0] OFF_DEADBAND = 4'h3;
   localparam logic [ADDR_W-1:0] OFF_MIN_PULSE = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_RELOAD = 4'h5;
   localparam logic [ADDR_W-1:0] OFF_DUTY_BASE = 4'h6;
   localparam logic [ADDR_W-1:0] OFF_DUTY_LAST = 4'hb;
   localparam logic [ADDR_W-1:0] OFF_COUNT = 4'hc;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hd;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CA_RUN = 0;
   localparam int CA_READY = 1;
   localparam int CA_TRIG = 2;
   localparam int CA_CENTRE = 3;
   localparam int CB_DIV_LSB = 0;
   localparam int CB_RELF_LSB = 2;
   localparam int CB_INDEP = 4;
   localparam int CB_POL_LSB = 5;
   localparam int OV_FORCE_LSB = 0;
   localparam int OV_MANUAL = 6;
   localparam int ST_PINS_LSB = 0;
   localparam int ST_READY = 6;
   localparam int ST_MOTOR_OUTPUTS_ENABLE_OPTION = 7;
   localparam int ST_DOWN = 8;

   // ------------------------------------------------------------
   // reset values and small constants
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0] RELOAD_RST = 12'hfff;
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
   localparam logic [DB_W-1:0] DB_LAST = 8'h01;
   localparam logic [2:0] PER_ONE = 3'h1;
   localparam logic [2:0] PRE_ONE = 3'h1;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NUM_PAIRS-1:0] high;
      logic [NUM_PAIRS-1:0] low;
   } mpm_pins_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } mpm_bus_t;

endpackage

// File: dv/mpm_checker.sv
// port-level checks for the motor modulator, bound onto mpm_top.
// assumes the register map of mpm_pkg and a reload value of 2 or more.
`timescale 1ns/1ps

module mpm_checker #(
   parameter logic [11:0] RELOAD_RESET = mpm_pkg::RELOAD_RST
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // straps
   input wire logic high_side_offstate_option_in,
   input wire logic low_side_offstate_option_in,
   input wire logic motor_outputs_enable_option_in,
   // register port
   input wire mpm_pkg::mpm_bus_t bus_in,
   input wire logic [15:0] rdata_out,
   // pins and trigger
   input wire mpm_pkg::mpm_pins_t pin_sense_in,
   input wire mpm_pkg::mpm_pins_t pin_level_out,
   input wire mpm_pkg::mpm_pins_t pin_oe_out,
   input wire logic conv_trig_out
);
   import mpm_pkg::*;
   // ----
   // shadow of the control bits
   // ----
   logic run_q, trig_q, indep_q;
   logic [6:0] ov_q;
   logic [1:0] settle_q;
   wire wr_a = bus_in.wr && bus_in.addr == OFF_CTRL_A;
   wire wr_b = bus_in.wr && bus_in.addr == OFF_CTRL_B;
   wire wr_o = bus_in.wr && bus_in.addr == OFF_OVERRIDE;
   wire settled = settle_q == 2'h3;
   wire [5:0] offv = {{3{high_side_offstate_option_in}},
      {3{low_side_offstate_option_in}}};
   wire [5:0] act = pin_level_out ^ offv;
   wire [5:0] mask = ov_q[6] ? {ov_q[2:0], ov_q[5:3]} : 6'h00;

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         {run_q, trig_q, indep_q, ov_q, settle_q} <= '0;
      end else begin
         settle_q <= settled ? settle_q : settle_q + 2'h1;
         if (wr_a) begin
            run_q <= bus_in.wdata[CA_RUN];
            trig_q <= bus_in.wdata[CA_TRIG];
         end
         if (wr_b) begin
            indep_q <= bus_in.wdata[CB_INDEP];
         end
         if (wr_o) begin
            ov_q <= bus_in.wdata[6:0];
         end
      end
   end

   // ----
   // properties
   // ----
   default clocking cb_chk @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_release;
      $fell(sys_rst_in) && motor_outputs_enable_option_in;
   endsequence
   sequence s_status_rd;
      bus_in.rd && bus_in.addr == OFF_STATUS ##1 1'b1;
   endsequence

   property p_oe_off;
      !motor_outputs_enable_option_in |-> pin_oe_out == 6'h00;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("pins driven while outputs disabled");
   property p_oe_on;
      s_release |-> ##[1:3] pin_oe_out == 6'h3f;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("pins not driven after reset");
   property p_idle;
      settled && !run_q && !$past(run_q) && !$past(run_q, 2)
         && pin_oe_out == 6'h3f |-> pin_level_out == offv;
   endproperty
   a_idle: assert property (p_idle)
      else $error("stopped pins not at off level");
   property p_overlap;
      settled && !indep_q && !$past(indep_q) && !$past(indep_q, 2)
         |-> (act[5:3] & act[2:0]) == 3'h0;
   endproperty
   a_overlap: assert property (p_overlap)
      else $error("both sides of a pair active");
   property p_manual;
      settled && mask == $past(mask) && mask == $past(mask, 2)
         |-> (act & mask) == 6'h00;
   endproperty
   a_manual: assert property (p_manual)
      else $error("forced channel not at off level");
   property p_trig_gate;
      conv_trig_out |-> trig_q || $past(trig_q) || $past(trig_q, 2);
   endproperty
   a_trig_gate: assert property (p_trig_gate)
      else $error("trigger while disabled");
   property p_trig_pulse;
      conv_trig_out |=> !conv_trig_out;
   endproperty
   a_trig_pulse: assert property (p_trig_pulse)
      else $error("trigger longer than one cycle");
   property p_status;
      s_status_rd |-> rdata_out[ST_MOTOR_OUTPUTS_ENABLE_OPTION] == motor_outputs_enable_option_in
         && rdata_out[5:0] == $past(pin_sense_in);
   endproperty
   a_status: assert property (p_status)
      else $error("status read wrong");
   property p_rd_idle;
      !$past(bus_in.rd) |-> rdata_out == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read slot");
endmodule

bind mpm_top mpm_checker #(.RELOAD_RESET(RELOAD_RESET)) u_checker (
   .clk_in(clk_in),
   .sys_rst_in(sys_rst_in),
   .high_side_offstate_option_in(high_side_offstate_option_in),
   .low_side_offstate_option_in(low_side_offstate_option_in),
   .motor_outputs_enable_option_in(motor_outputs_enable_option_in),
   .bus_in(bus_in),
   .rdata_out(rdata_out),
   .pin_sense_in(pin_sense_in),
   .pin_level_out(pin_level_out),
   .pin_oe_out(pin_oe_out),
   .conv_trig_out(conv_trig_out)
);

// File: dv/mpm_gate_drv.sv
// gate drive stage model: hands the pin levels back to the modulator.
// assumes one system clock and pins with no pull resistors.
`timescale 1ns/1ps

module mpm_gate_drv (
   // clock
   input wire logic clk_in,
   // pins from the modulator
   input wire mpm_pkg::mpm_pins_t pin_level_in,
   input wire mpm_pkg::mpm_pins_t pin_oe_in,
   // read-back
   output mpm_pkg::mpm_pins_t pin_sense_out
);
   import mpm_pkg::*;
   logic [5:0] float_q = 6'h2a;

   // undriven pin has no pull: show a pattern that flips every cycle
   always @(posedge clk_in) float_q <= ~float_q;
   assign pin_sense_out = (pin_level_in & pin_oe_in) | (float_q & ~pin_oe_in);
endmodule

// File: dv/tb_top.sv
// self-checking bench for the motor modulator with a gate drive model.
// assumes mpm_top, mpm_gate_drv and the bound checker are compiled first.
`timescale 1ns/1ps

module tb_top;
   import mpm_pkg::*;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic hs_opt = 1'b1;
   logic ls_opt = 1'b0;
   logic mc_opt = 1'b1;
   mpm_bus_t bus_q = '0;
   logic [15:0] rdata;
   logic [5:0] lvl, oe_v, sense;
   logic trig;
   logic [31:0] seed = 32'hc66162c1;
   logic [11:0] rld;
   logic [15:0] dv [6];
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_trig = 0;
   int t_trig = 0;
   int per;
   int act [6];
   int e [6];

   always #12.5 clk_in = ~clk_in;

   mpm_top u_dut (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .high_side_offstate_option_in(hs_opt),
      .low_side_offstate_option_in(ls_opt),
      .motor_outputs_enable_option_in(mc_opt),
      .bus_in(bus_q),
      .rdata_out(rdata),
      .pin_sense_in(sense),
      .pin_level_out(lvl),
      .pin_oe_out(oe_v),
      .conv_trig_out(trig)
   );
   mpm_gate_drv u_drv (
      .clk_in(clk_in),
      .pin_level_in(lvl),
      .pin_oe_in(oe_v),
      .pin_sense_out(sense)
   );

   // ----
   // helpers
   // ----
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // pair activity per period: deadband eats both edges of a toggling pair
   function automatic int exp_act(bit hi, bit pol, int on, int p, int db);
      int h;
      h = pol ? p - on : on;
      if (on > 0 && on < p) return (hi ? h : p - h) - db;
      return hi ? h : p - h;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %0h want %0h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      bus_q <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_in);
      bus_q <= '0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_in);
      bus_q <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk_in);
      bus_q <= '0;
      #1 d = rdata;
   endtask
   // stop, load while stopped so ready transfers at once, then run
   task automatic start(input logic [15:0] cb, input logic [15:0] ca);
      for (int i = 0; i < 6; i++) wr(OFF_DUTY_BASE + 4'(i), dv[i]);
      wr(OFF_CTRL_A, 16'h0000);
      wr(OFF_CTRL_B, cb);
      wr(OFF_RELOAD, {4'h0, rld});
      wr(OFF_CTRL_A, 16'h0002);
      wr(OFF_CTRL_A, ca | 16'h0001);
      repeat (3 * per) @(posedge clk_in);
   endtask
   task automatic measure();
      act = '{default: 0};
      repeat (per) begin
         @(posedge clk_in);
         for (int i = 0; i < 6; i++)
            act[i] += int'((lvl[i] ^ (i > 2 ? hs_opt : ls_opt)) === 1'b1);
      end
   endtask
   task automatic cmp_all();
      for (int i = 0; i < 6; i++) check(act[i], e[i]);
   endtask
   task automatic wait_trig(output int t);
      int k;
      k = n_trig;
      repeat (3000) if (n_trig == k) @(posedge clk_in);
      t = t_trig;
   endtask

   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (trig === 1'b1) begin
         n_trig <= n_trig + 1;
         t_trig <= cyc;
      end
   end

   initial begin
      // whole sequence needs well under 20000 cycles
      repeat (60000) @(posedge clk_in);
      mismatches++;
      conclude();
   end

   initial begin
      logic [15:0] d;
      int t1, t2, k, dh, db, on;
      dv = '{default: 16'h0000};
      repeat (20) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      check(oe_v, 32'h3f);
      check(lvl, 32'h38);
      rd(OFF_RELOAD, d);
      check(d, 32'hfff);
      rd(4'he, d);
      check(d, 32'h0);
      wr(OFF_STATUS, 16'hffff);
      rd(OFF_STATUS, d);
      check(d, 32'hb8);
      for (int m = 0; m < 8; m++) begin
         rld = 12'(rnd() % 32 + 20);
         per = int'(rld) + 1;
         start(16'(m % 4), 16'(m / 4 * 8 + 4));
         wait_trig(t1);
         wait_trig(t2);
         check(t2 - t1, (m < 4 ? per : rld) << (m % 4));
      end
      rld = 12'h014;
      per = 21;
      for (int f = 0; f < 4; f++) begin
         start(16'(f * 4), 16'h0004);
         wr(OFF_DUTY_BASE, 16'h0005);
         k = n_trig;
         wr(OFF_CTRL_A, 16'h0007);
         d = 16'h0040;
         repeat (200) if (d[ST_READY] === 1'b1) rd(OFF_STATUS, d);
         check(n_trig - k >= 1 && n_trig - k <= (1 << f) + 1, 1);
      end
      rld = 12'h01f;
      per = 32;
      dh = rnd() % 31 + 1;
      dv = '{16'h0000, 16'hfffb, 16'h0020, 16'h001f, 16'(dh), 16'h8000};
      start(16'h0010, 16'h0000);
      measure();
      e = '{0, 31, 0, 0, 32, dh};
      cmp_all();
      wr(OFF_DUTY_BASE + 4'h4, 16'h0001);
      measure();
      cmp_all();
      for (int v = 0; v < 3; v++) begin
         dh = rnd() % 8 + 8;
         db = rnd() % 4 + 1;
         dv = '{16'(dh), 16'(rnd()), 16'(dh), 16'(rnd()), 16'h0000,
            16'(rnd())};
         wr(OFF_DEADBAND, 16'(db));
         wr(OFF_MIN_PULSE, v == 1 ? 16'(dh - db + 1) : 16'h0000);
         wr(OFF_OVERRIDE, v == 2 ? 16'h0041 : 16'h0010);
         start(16'h0040, 16'h0000);
         measure();
         on = v == 1 ? 0 : dh;
         e = '{exp_act(0, 0, on, per, db), exp_act(0, 1, on, per, db),
            per, exp_act(1, 0, on, per, db), exp_act(1, 1, on, per, db), 0};
         if (v == 2) e[3] = 0;
         cmp_all();
      end
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      mc_opt <= 1'b0;
      hs_opt <= 1'b0;
      ls_opt <= 1'b1;
      repeat (20) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      repeat (5) @(posedge clk_in);
      check(oe_v, 32'h0);
      check(lvl, 32'h07);
      rd(OFF_STATUS, d);
      check(d[ST_MOTOR_OUTPUTS_ENABLE_OPTION], 32'h0);
      conclude();
   end
endmodule

// File: logic/mpm_top.sv
// six-output motor modulator: prescaler, shared 12-bit counter, buffered
// duty compare, deadband, pulse filter, override and converter trigger.
// assumes all inputs synchronous to clk_in; option straps stable at reset.
`timescale 1ns/1ps

module mpm_top #(
   parameter logic [mpm_pkg::CNT_W-1:0] RELOAD_RESET = mpm_pkg::RELOAD_RST
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // option straps
   input wire logic high_side_offstate_option_in,
   input wire logic low_side_offstate_option_in,
   input wire logic motor_outputs_enable_option_in,
   // register port
   input wire mpm_pkg::mpm_bus_t bus_in,
   output logic [mpm_pkg::DATA_W-1:0] rdata_out,
   // pins
   input wire mpm_pkg::mpm_pins_t pin_sense_in,
   output mpm_pkg::mpm_pins_t pin_level_out,
   output mpm_pkg::mpm_pins_t pin_oe_out,
   // converter trigger
   output logic conv_trig_out
);
   import mpm_pkg::*;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [2:0] div_mask(input logic [1:0] sel);
      case (sel)
         2'h0: div_mask = 3'h0;
         2'h1: div_mask = 3'h1;
         2'h2: div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   endfunction

   // on/off level of one modulated channel before deadband
   function automatic logic chan_on(
      input logic [DUTY_W-1:0] duty,
      input logic [CNT_W-1:0] cnt,
      input logic [CNT_W-1:0] rld,
      input logic ctr,
      input logic [DB_W:0] dbm,
      input logic [DB_W-1:0] thr
   );
      logic [WID_W-1:0] per;
      logic [WID_W-1:0] on_w;
      logic [WID_W-1:0] off_w;
      logic [WID_W-1:0] need;
      per = ctr ? {1'b0, rld, 1'b0} : ({2'h0, rld} + 14'h0001);
      on_w = ctr ? {1'b0, duty[CNT_W-1:0], 1'b0} : {2'h0, duty[CNT_W-1:0]};
      off_w = per - on_w;
      need = {5'h00, dbm} + {6'h00, thr};
      if (duty[DUTY_W-1] || duty == '0) begin
         chan_on = 1'b0;
      end else if (duty[DUTY_W-2:0] > {3'h0, rld}) begin
         chan_on = 1'b1;
      end else if (on_w < need) begin
         chan_on = 1'b0;
      end else if (off_w < need) begin
         chan_on = 1'b1;
      end else begin
         chan_on = cnt < duty[CNT_W-1:0];
      end
   endfunction

   // ------------------------------------------------------------
   // option capture after reset release
   // ------------------------------------------------------------
   logic opt_loaded_q;
   logic hi_off_q;
   logic lo_off_q;
   logic motor_outputs_enable_option_q;

   // straps are caught by the clock, never through the async reset
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         opt_loaded_q <= 1'b0;
         hi_off_q <= 1'b0;
         lo_off_q <= 1'b0;
         motor_outputs_enable_option_q <= 1'b0;
      end else if (!opt_loaded_q) begin
         opt_loaded_q <= 1'b1;
         hi_off_q <= high_side_offstate_option_in;
         lo_off_q <= low_side_offstate_option_in;
         motor_outputs_enable_option_q <= motor_outputs_enable_option_in;
      end
   end

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   wire wr_ctrl_a = bus_in.wr && bus_in.addr == OFF_CTRL_A;
   wire wr_ctrl_b = bus_in.wr && bus_in.addr == OFF_CTRL_B;
   wire wr_ovr = bus_in.wr && bus_in.addr == OFF_OVERRIDE;
   wire wr_db = bus_in.wr && bus_in.addr == OFF_DEADBAND;
   wire wr_thr = bus_in.wr && bus_in.addr == OFF_MIN_PULSE;
   wire wr_rld = bus_in.wr && bus_in.addr == OFF_RELOAD;
   wire in_duty = bus_in.addr >= OFF_DUTY_BASE &&
      bus_in.addr <= OFF_DUTY_LAST;
   wire wr_duty = bus_in.wr && in_duty;
   wire [2:0] duty_idx = 3'(bus_in.addr - OFF_DUTY_BASE);

   logic run_q;
   logic ready_q;
   logic trig_en_q;
   logic centre_q;
   logic [1:0] div_buf_q;
   logic [1:0] relf_q;
   logic independent_outputs_select_q;
   logic [NUM_PAIRS-1:0] pol_q;
   logic man_ctl_q;
   logic [NUM_CH-1:0] force_off_q;
   logic [DB_W-1:0] db_q;
   logic [DB_W-1:0] thr_q;
   logic [CNT_W-1:0] rld_buf_q;
   logic [DUTY_W-1:0] duty_buf_q [NUM_CH];

   // active copies used by the modulator
   logic [1:0] div_act_q;
   logic [CNT_W-1:0] rld_act_q;
   logic [DUTY_W-1:0] duty_act_q [NUM_CH];

   // counter state
   logic [2:0] pre_cnt_q;
   logic [2:0] per_cnt_q;
   logic [CNT_W-1:0] cnt_q;
   logic down_q;

   // ------------------------------------------------------------
   // time base
   // ------------------------------------------------------------
   wire [2:0] pre_mask = div_mask(div_act_q);
   wire [2:0] relf_mask = div_mask(relf_q);
   wire tick = run_q && pre_cnt_q == pre_mask;
   wire at_top = cnt_q >= rld_act_q;
   wire zero_rld = rld_act_q == '0;
   wire edge_end = tick && !centre_q && at_top;
   wire ctr_end = tick && centre_q &&
      ((down_q && cnt_q <= CNT_ONE) || zero_rld);
   wire period_end = edge_end || ctr_end;
   wire mid_point = tick && centre_q && !down_q &&
      cnt_q + CNT_ONE == rld_act_q;
   wire reload_evt = period_end &&
      (per_cnt_q & relf_mask) == relf_mask;
   // while stopped, ready values go straight in so the first period is right
   wire load = ready_q && (reload_evt || !run_q);

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         run_q <= 1'b0;
         trig_en_q <= 1'b0;
         centre_q <= 1'b0;
         div_buf_q <= '0;
         relf_q <= '0;
         independent_outputs_select_q <= 1'b0;
         pol_q <= '0;
         man_ctl_q <= 1'b0;
         force_off_q <= '0;
         db_q <= '0;
         thr_q <= '0;
         rld_buf_q <= RELOAD_RESET;
      end else begin
         if (wr_ctrl_a) begin
            run_q <= bus_in.wdata[CA_RUN];
            trig_en_q <= bus_in.wdata[CA_TRIG];
            centre_q <= bus_in.wdata[CA_CENTRE];
         end
         if (wr_ctrl_b) begin
            div_buf_q <= bus_in.wdata[CB_DIV_LSB +: 2];
            relf_q <= bus_in.wdata[CB_RELF_LSB +: 2];
            independent_outputs_select_q <= bus_in.wdata[CB_INDEP];
            pol_q <= bus_in.wdata[CB_POL_LSB +: NUM_PAIRS];
         end
         if (wr_ovr) begin
            force_off_q <= bus_in.wdata[OV_FORCE_LSB +: NUM_CH];
            man_ctl_q <= bus_in.wdata[OV_MANUAL];
         end
         if (wr_db) begin
            db_q <= bus_in.wdata[DB_W-1:0];
         end
         if (wr_thr) begin
            thr_q <= bus_in.wdata[DB_W-1:0];
         end
         if (wr_rld) begin
            rld_buf_q <= bus_in.wdata[CNT_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < NUM_CH; i++) begin
            duty_buf_q[i] <= '0;
         end
      end else if (wr_duty) begin
         duty_buf_q[duty_idx] <= bus_in.wdata;
      end
   end

   // a set from software in the transfer cycle wins over the clear
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ready_q <= 1'b0;
      end else if (wr_ctrl_a && bus_in.wdata[CA_READY]) begin
         ready_q <= 1'b1;
      end else if (load) begin
         ready_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // buffered transfer
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         div_act_q <= '0;
         rld_act_q <= RELOAD_RESET;
         for (int i = 0; i < NUM_CH; i++) begin
            duty_act_q[i] <= '0;
         end
      end else if (load) begin
         div_act_q <= div_buf_q;
         rld_act_q <= rld_buf_q;
         for (int i = 0; i < NUM_CH; i++) begin
            duty_act_q[i] <= duty_buf_q[i];
         end
      end
   end

   // ------------------------------------------------------------
   // prescaler and master counter
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pre_cnt_q <= '0;
         per_cnt_q <= '0;
         cnt_q <= '0;
         down_q <= 1'b0;
      end else if (!run_q) begin
         pre_cnt_q <= '0;
         per_cnt_q <= '0;
         cnt_q <= '0;
         down_q <= 1'b0;
      end else begin
         pre_cnt_q <= tick ? '0 : pre_cnt_q + PRE_ONE;
         if (period_end) begin
            per_cnt_q <= per_cnt_q + PER_ONE;
         end
         if (tick) begin
            if (!centre_q) begin
               cnt_q <= at_top ? '0 : cnt_q + CNT_ONE;
               down_q <= 1'b0;
            end else if (zero_rld) begin
               cnt_q <= '0;
               down_q <= 1'b0;
            end else if (!down_q) begin
               cnt_q <= at_top ? rld_act_q - CNT_ONE : cnt_q + CNT_ONE;
               down_q <= at_top;
            end else if (cnt_q <= CNT_ONE) begin
               cnt_q <= '0;
               down_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q - CNT_ONE;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // compare, deadband and channel activity
   // ------------------------------------------------------------
   // deadband in modulator clocks, rounded up, for the width filter
   wire [DB_W:0] db_mod = ({1'b0, db_q} + {6'h00, pre_mask}) >> div_act_q;

   logic [NUM_PAIRS-1:0] tgt;
   logic [NUM_PAIRS-1:0] ind_hi;
   logic [NUM_PAIRS-1:0] ind_lo;
   logic [NUM_PAIRS-1:0] act_hi;
   logic [NUM_PAIRS-1:0] act_lo;
   logic [NUM_PAIRS-1:0] applied_q;
   logic [NUM_PAIRS-1:0] dead_q;
   logic [DB_W-1:0] dbc_q [NUM_PAIRS];

   for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
      // complementary pair uses the high-side duty only
      assign tgt[p] = chan_on(duty_act_q[2*p], cnt_q, rld_act_q, centre_q,
         db_mod, thr_q) ^ pol_q[p];
      assign ind_hi[p] = chan_on(duty_act_q[2*p], cnt_q, rld_act_q,
         centre_q, '0, thr_q);
      assign ind_lo[p] = chan_on(duty_act_q[2*p+1], cnt_q, rld_act_q,
         centre_q, '0, thr_q);
      assign act_hi[p] = independent_outputs_select_q ? ind_hi[p] :
         (!dead_q[p] && applied_q[p]);
      assign act_lo[p] = independent_outputs_select_q ? ind_lo[p] :
         (!dead_q[p] && !applied_q[p]);
   end

   // deadband runs on system clocks so it is immune to the prescaler
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         applied_q <= '0;
         dead_q <= '0;
         for (int p = 0; p < NUM_PAIRS; p++) begin
            dbc_q[p] <= '0;
         end
      end else begin
         for (int p = 0; p < NUM_PAIRS; p++) begin
            if (dead_q[p]) begin
               if (dbc_q[p] <= DB_LAST) begin
                  dead_q[p] <= 1'b0;
                  applied_q[p] <= tgt[p];
               end else begin
                  dbc_q[p] <= dbc_q[p] - DB_LAST;
               end
            end else if (tgt[p] != applied_q[p]) begin
               if (db_q == '0) begin
                  applied_q[p] <= tgt[p];
               end else begin
                  dead_q[p] <= 1'b1;
                  dbc_q[p] <= db_q;
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   wire man = man_ctl_q;
   wire [NUM_PAIRS-1:0] kill_hi = {NUM_PAIRS{man}} &
      force_off_q[OV_FORCE_LSB +: NUM_PAIRS];
   wire [NUM_PAIRS-1:0] kill_lo = {NUM_PAIRS{man}} &
      force_off_q[OV_FORCE_LSB + NUM_PAIRS +: NUM_PAIRS];
   wire [NUM_PAIRS-1:0] on_hi = {NUM_PAIRS{run_q}} & act_hi & ~kill_hi;
   wire [NUM_PAIRS-1:0] on_lo = {NUM_PAIRS{run_q}} & act_lo & ~kill_lo;
   wire drive = opt_loaded_q && motor_outputs_enable_option_q;

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_level_out <= '0;
         pin_oe_out <= '0;
      end else begin
         pin_level_out.high <= {NUM_PAIRS{hi_off_q}} ^ on_hi;
         pin_level_out.low <= {NUM_PAIRS{lo_off_q}} ^ on_lo;
         pin_oe_out.high <= {NUM_PAIRS{drive}};
         pin_oe_out.low <= {NUM_PAIRS{drive}};
      end
   end

   // ------------------------------------------------------------
   // converter trigger
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         conv_trig_out <= 1'b0;
      end else begin
         conv_trig_out <= trig_en_q && (period_end || mid_point);
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   wire [DATA_W-1:0] rd_ctrl_a = DATA_W'({centre_q, trig_en_q, ready_q,
      run_q});
   wire [DATA_W-1:0] rd_ctrl_b = DATA_W'({pol_q, independent_outputs_select_q, relf_q,
      div_buf_q});
   wire [DATA_W-1:0] rd_ovr = DATA_W'({man_ctl_q, force_off_q});
   wire [DATA_W-1:0] rd_status = DATA_W'({down_q, motor_outputs_enable_option_q, ready_q,
      6'(pin_sense_in)});
   wire [DATA_W-1:0] rd_mux =
      bus_in.addr == OFF_CTRL_A ? rd_ctrl_a :
      bus_in.addr == OFF_CTRL_B ? rd_ctrl_b :
      bus_in.addr == OFF_OVERRIDE ? rd_ovr :
      bus_in.addr == OFF_DEADBAND ? DATA_W'(db_q) :
      bus_in.addr == OFF_MIN_PULSE ? DATA_W'(thr_q) :
      bus_in.addr == OFF_RELOAD ? DATA_W'(rld_buf_q) :
      in_duty ? duty_buf_q[duty_idx] :
      bus_in.addr == OFF_COUNT ? DATA_W'(cnt_q) :
      bus_in.addr == OFF_STATUS ? rd_status : '0;

   // data stands only in the cycle after the read strobe
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= bus_in.rd ? rd_mux : '0;
      end
   end

endmodule
